// File: core/dmem_regs.svh
`ifndef DMEM_REGS_SVH
`define DMEM_REGS_SVH
`define USER_RAM_DEPTH 192
`define USER_RAM_LAST 8'hbf
`define CTRL_FIRST 8'hc0
`define PAGE_SEL_ADDR 8'hf3
`define STACK_LAST 8'hbf
`define VECTOR_BASE 16'hffe0
`define RESET_VEC_IDX 4'hf
`define DISP_PREFIX 1'b1
`endif

// File: core/dmem_pkg.sv
package dmem_pkg;
   typedef enum logic [1:0] {
      REG_USER, REG_CTRL, REG_STACK, REG_DISPLAY
   } region_t;
   typedef enum logic [2:0] {
      STK_NONE, STK_CALL, STK_IRQ, STK_RET, STK_INTERRUPT_RETURN
   } stack_op_t;
   typedef struct packed {
      logic wr;
      logic rd;
      logic disp;
      logic [7:0] addr;
      logic [7:0] wdata;
   } mem_req_t;
endpackage

// File: core/page_select.sv
`timescale 1ns/1ps
`include "dmem_regs.svh"
module page_select (
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic i_wr,
   input wire logic i_bytewide,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_direct_page,
   output logic [1:0] o_ram_page_select,
   output logic o_page
);
   logic [1:0] ram_page_select_q;
   // only bit 0 selects a page; the second bit is stored but unused here
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         ram_page_select_q <= 2'h0;
      end else if (i_wr && i_bytewide && i_addr == `PAGE_SEL_ADDR) begin
         ram_page_select_q <= i_wdata[1:0]; // [R17]
      end
   end
   assign o_ram_page_select = ram_page_select_q;
   assign o_page = i_direct_page & ram_page_select_q[0]; // [R3] [R4] [R5]
   page_zero_a: assert property (@(posedge i_clock) // [R4]
      disable iff (!i_rst_n) !i_direct_page |-> !o_page)
      else $error("page not zero");
   page_follow_a: assert property (@(posedge i_clock) // [R5]
      disable iff (!i_rst_n) i_direct_page |-> o_page == ram_page_select_q[0])
      else $error("page not from select");
endmodule

// File: core/data_memory_paging_stack.sv
`timescale 1ns/1ps
`include "dmem_regs.svh"
// How it works
// R1 - decode data space into user ram, control, stack and display regions
// R2 - user ram holds 192 eight-bit locations, read and written by cpu
// R3 - two ram pages chosen by direct-page flag and page select
// R4 - flag clear selects page 0 regardless of page select
// R5 - flag set takes page from page select register
// R6 - control registers live from c0 to ff
// R7 - unimplemented control addresses read anything, writes undefined
// R8 - write-only registers take only whole-byte writes
// R9 - call or interrupt pushes return address before control transfer
// R10 - subroutine return pops only the program counter
// R11 - interrupt return pops program counter and status flags
// R12 - pointer marks next push; decrement after store, increment before load
// R13 - vectors are word pairs from vector base, reset in last word
// R14 - stack may sit anywhere from 00 to bf
// R15 - stack pointer has no reset value until software writes it
// R16 - flag clear gives direct addressing over zero page 00 to ff
// R17 - page select register sits at address f3
module data_memory_paging_stack
   import dmem_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire mem_req_t i_req,
   input wire logic i_bytewide,
   input wire logic i_direct_page,
   input wire logic [7:0] i_ctrl_rdata,
   input wire stack_op_t i_stack_op,
   input wire logic [15:0] i_return_pc,
   input wire logic [7:0] i_status,
   input wire logic i_sp_wr,
   input wire logic [7:0] i_sp_wdata,
   input wire logic [3:0] i_vector_idx,
   input wire logic i_reset_fetch,
   output region_t o_region,
   output logic [7:0] o_rdata,
   output logic o_ctrl_wr,
   output logic o_ctrl_rd,
   output logic [7:0] o_stack_pointer,
   output logic o_stack_busy,
   output logic o_pop_valid,
   output logic [15:0] o_pop_pc,
   output logic [7:0] o_pop_status,
   output logic o_pop_has_status,
   output logic [15:0] o_vector_addr,
   output logic [1:0] o_ram_page_select
);
   localparam int DEPTH = `USER_RAM_DEPTH;
   typedef enum {S_IDLE, S_PUSH, S_POP} stk_state_t;

   // ----------------------------------------
   // region decode
   // ----------------------------------------
   function automatic region_t decode(input logic disp, input logic [7:0] a);
      if (disp == `DISP_PREFIX) decode = REG_DISPLAY;
      else if (a >= `CTRL_FIRST) decode = REG_CTRL; // [R6]
      else decode = REG_USER;
   endfunction

   region_t region;
   logic page;
   stk_state_t state_q;
   logic [1:0] cnt_q;
   logic [1:0] nbytes_q;
   logic [23:0] shift_q;
   logic [7:0] sp_q;
   logic [7:0] ram_q [2][DEPTH];
   logic [7:0] rdata_q;
   logic [7:0] stk_byte;
   logic [7:0] sp_pop;
   logic with_status_q;
   logic pop_valid_q;

   always_comb begin
      region = decode(i_req.disp, i_req.addr); // [R1] [R16]
      if (region == REG_USER && state_q != S_IDLE) region = REG_STACK;
   end
   assign o_region = region;

   page_select u_page (
      .i_clock(i_clock),
      .i_rst_n(i_rst_n),
      // a display write at the same offset must not move the page
      .i_wr(i_req.wr && region == REG_CTRL),
      .i_bytewide(i_bytewide),
      .i_addr(i_req.addr),
      .i_wdata(i_req.wdata),
      .i_direct_page(i_direct_page),
      .o_ram_page_select(o_ram_page_select),
      .o_page(page)
   );

   // control window handed to peripherals; gaps give whatever they drive
   assign o_ctrl_wr = i_req.wr && i_bytewide // [R7] [R8]
      && region == REG_CTRL;
   assign o_ctrl_rd = i_req.rd && region == REG_CTRL;

   // ----------------------------------------
   // stack sequencer
   // ----------------------------------------
   assign sp_pop = sp_q + 8'h01;
   assign stk_byte = shift_q[7:0];
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         state_q <= S_IDLE;
         cnt_q <= 2'h0;
         nbytes_q <= 2'h0;
         shift_q <= 24'h0;
         with_status_q <= 1'b0;
      end else begin
         case (state_q)
            S_IDLE: begin
               cnt_q <= 2'h0;
               case (i_stack_op)
                  STK_CALL: begin // [R9]
                     state_q <= S_PUSH;
                     nbytes_q <= 2'h2;
                     shift_q <= {8'h00, i_return_pc[7:0], i_return_pc[15:8]};
                  end
                  STK_IRQ: begin // [R9]
                     state_q <= S_PUSH;
                     nbytes_q <= 2'h3;
                     shift_q <= {i_status, i_return_pc[7:0],
                                 i_return_pc[15:8]};
                  end
                  STK_RET: begin // [R10]
                     state_q <= S_POP;
                     nbytes_q <= 2'h2;
                     with_status_q <= 1'b0;
                  end
                  STK_INTERRUPT_RETURN: begin // [R11]
                     state_q <= S_POP;
                     nbytes_q <= 2'h3;
                     with_status_q <= 1'b1;
                  end
                  default: state_q <= S_IDLE;
               endcase
            end
            S_PUSH: begin
               shift_q <= {8'h00, shift_q[23:8]};
               cnt_q <= cnt_q + 2'h1;
               if (cnt_q + 2'h1 == nbytes_q) state_q <= S_IDLE;
            end
            S_POP: begin
               // popped order: status first on interrupt return, then pc
               shift_q <= {shift_q[15:0], ram_q[0][sp_pop]};
               cnt_q <= cnt_q + 2'h1;
               if (cnt_q + 2'h1 == nbytes_q) state_q <= S_IDLE;
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end
   assign o_stack_busy = state_q != S_IDLE;

   // no reset: software must load the pointer before using the stack
   always_ff @(posedge i_clock) begin // [R15]
      if (i_sp_wr) sp_q <= i_sp_wdata;
      else if (state_q == S_PUSH) sp_q <= sp_q - 8'h01; // [R12]
      else if (state_q == S_POP) sp_q <= sp_pop; // [R12]
   end
   assign o_stack_pointer = sp_q;

   always_ff @(posedge i_clock) begin
      if (!i_rst_n) pop_valid_q <= 1'b0;
      else pop_valid_q <= state_q == S_POP && cnt_q + 2'h1 == nbytes_q;
   end
   assign o_pop_valid = pop_valid_q;
   assign o_pop_pc = {shift_q[7:0], shift_q[15:8]};
   assign o_pop_status = with_status_q ? shift_q[23:16] : 8'h00;
   assign o_pop_has_status = with_status_q;

   // ----------------------------------------
   // user ram, two pages; stack lives in page 0
   // ----------------------------------------
   always_ff @(posedge i_clock) begin
      if (state_q == S_PUSH && sp_q <= `STACK_LAST) begin
         ram_q[0][sp_q] <= stk_byte; // [R12] [R14]
      end else if (i_req.wr && region == REG_USER) begin
         ram_q[page][i_req.addr] <= i_req.wdata; // [R2] [R3]
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_rst_n) rdata_q <= 8'h00;
      else if (i_req.rd && region == REG_USER)
         rdata_q <= ram_q[page][i_req.addr]; // [R2]
      else if (i_req.rd && region == REG_CTRL)
         rdata_q <= i_ctrl_rdata; // [R7]
      else if (i_req.rd) rdata_q <= 8'h00;
   end
   assign o_rdata = rdata_q;

   // ----------------------------------------
   // vector table
   // ----------------------------------------
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) o_vector_addr <= `VECTOR_BASE + {`RESET_VEC_IDX, 1'b0};
      else if (i_reset_fetch)
         o_vector_addr <= `VECTOR_BASE + {11'h0, `RESET_VEC_IDX, 1'b0};
      else o_vector_addr <= `VECTOR_BASE + {11'h0, i_vector_idx, 1'b0};
   end // [R13]

   // ----------------------------------------
   // checks
   // ----------------------------------------
   ctrl_window_a: assert property (@(posedge i_clock) // [R6]
      disable iff (!i_rst_n) o_ctrl_wr |-> i_req.addr >= `CTRL_FIRST)
      else $error("ctrl decode");
   byte_only_a: assert property (@(posedge i_clock) // [R8]
      disable iff (!i_rst_n) o_ctrl_wr |-> i_bytewide)
      else $error("partial ctrl write");
   push_dec_a: assert property (@(posedge i_clock) // [R12]
      disable iff (!i_rst_n)
      state_q == S_PUSH && !i_sp_wr |=> sp_q == $past(sp_q) - 8'h01)
      else $error("push did not decrement");
   call_len_a: assert property (@(posedge i_clock) // [R9]
      disable iff (!i_rst_n)
      state_q == S_IDLE && i_stack_op == STK_CALL |=> o_stack_busy [*2] ##1
      !o_stack_busy) else $error("call push length");
   interrupt_return_len_a: assert property (@(posedge i_clock) // [R11]
      disable iff (!i_rst_n)
      state_q == S_IDLE && i_stack_op == STK_INTERRUPT_RETURN |=> ##3 o_pop_valid
      && o_pop_has_status) else $error("interrupt_return pop length");
   ret_len_a: assert property (@(posedge i_clock) // [R10]
      disable iff (!i_rst_n)
      state_q == S_IDLE && i_stack_op == STK_RET |=> ##2 o_pop_valid
      && !o_pop_has_status) else $error("ret pop length");
   reset_vec_a: assert property (@(posedge i_clock) // [R13]
      disable iff (!i_rst_n) i_reset_fetch |=> o_vector_addr == 16'hfffe)
      else $error("reset vector");
   disp_region_a: assert property (@(posedge i_clock) // [R1]
      disable iff (!i_rst_n) i_req.disp |-> o_region == REG_DISPLAY)
      else $error("display");
   call_cov: cover property (@(posedge i_clock) i_stack_op == STK_CALL);
   interrupt_return_cov: cover property (@(posedge i_clock)
      o_pop_valid && o_pop_has_status);
   page1_cov: cover property (@(posedge i_clock) i_req.wr && page);
endmodule

// File: bench/periph_model.sv
`timescale 1ns/1ps
// ---------------------------------------------
// peripheral register blocks on the control bus
// ---------------------------------------------
module periph_model (
   input wire logic i_clock,
   input wire logic i_rd,
   input wire logic [7:0] i_addr,
   output logic [7:0] o_rdata
);
   logic [7:0] spin_q;
   // unselected bus shows a moving pattern, so stale data cannot match
   always @(posedge i_clock) begin
      spin_q <= spin_q + 8'h3b;
   end
   initial spin_q = 8'h00;
   assign o_rdata = i_rd ? ~i_addr : spin_q;
endmodule

// File: bench/testbench.sv
`timescale 1ns/1ps
module testbench;
   import dmem_pkg::*;
   logic clk, rst_n, bw, dp, sp_wr, rf, cwr, crs, busy, pv, phs, cws, crd;
   mem_req_t req;
   stack_op_t op;
   region_t rg, rgs;
   logic [15:0] rpc, va, ppc;
   logic [7:0] st, spd, prd, rdata, sp, pst;
   logic [3:0] vidx;
   logic [1:0] pg;
   int n_fail, n_compared;
   data_memory_paging_stack data_memory_paging_stack_i (.i_clock(clk),
      .i_rst_n(rst_n), .i_req(req), .i_bytewide(bw), .i_direct_page(dp),
      .i_ctrl_rdata(prd), .i_stack_op(op), .i_return_pc(rpc), .i_status(st),
      .i_sp_wr(sp_wr), .i_sp_wdata(spd), .i_vector_idx(vidx),
      .i_reset_fetch(rf), .o_region(rg), .o_rdata(rdata), .o_ctrl_wr(cwr),
      .o_ctrl_rd(crd), .o_stack_pointer(sp), .o_stack_busy(busy),
      .o_pop_valid(pv), .o_pop_pc(ppc), .o_pop_status(pst),
      .o_pop_has_status(phs), .o_vector_addr(va), .o_ram_page_select(pg));
   periph_model periph_model_i (.i_clock(clk), .i_rd(crd),
      .i_addr(req.addr), .o_rdata(prd));
   // -------------
   // shared tasks
   // -------------
   task automatic chk(input string nm, input logic [15:0] e, g);
      n_compared++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic acc(input logic w, r, d, input logic [7:0] a, wd);
      @(negedge clk);
      req = '{wr: w, rd: r, disp: d, addr: a, wdata: wd};
      #1;
      rgs = rg;
      cws = cwr;
      crs = crd;
      @(negedge clk);
      req = '0;
   endtask
   task automatic stk(input stack_op_t o, input logic [15:0] pc,
                      input logic [7:0] s);
      logic seen;
      seen = 1'b0;
      @(negedge clk);
      op = o;
      rpc = pc;
      st = s;
      @(negedge clk);
      op = STK_NONE;
      #1;
      chk("stk_region", 16'(REG_STACK), 16'(rg));
      // pop latency is three cycles for return, four for interrupt return, so eight cycles always cover it
      for (int i = 0; i < 8; i++) begin
         if (pv === 1'b1) seen = 1'b1;
         @(negedge clk);
      end
      if (o == STK_RET || o == STK_INTERRUPT_RETURN)
         chk("pop_valid", 1, 16'(seen));
      chk("busy", 0, 16'(busy));
   endtask
   task automatic close_out();
      $display("compared %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // ----------
   // scenarios
   // ----------
   task automatic t_vectors();
      for (int i = 0; i < 16; i++) begin
         @(negedge clk);
         vidx = i[3:0];
         repeat (2) @(negedge clk);
         chk("vec", 16'hffe0 + 16'(2 * i), va);
      end
      vidx = 4'h2;
      rf = 1'b1;
      repeat (2) @(negedge clk);
      chk("vec_force", 16'hfffe, va);
      rf = 1'b0;
   endtask
   task automatic t_regions();
      acc(1, 0, 0, 8'hc5, 8'h11);
      chk("ctrl_region", 16'(REG_CTRL), 16'(rgs));
      chk("ctrl_wr", 1, 16'(cws));
      acc(0, 1, 0, 8'hfe, 8'h00);
      chk("ctrl_rd", 1, 16'(crs));
      chk("ctrl_rdata", 16'h0001, 16'(rdata));
      acc(0, 1, 0, 8'hbf, 8'h00);
      chk("user_region", 16'(REG_USER), 16'(rgs));
      chk("user_no_rd", 0, 16'(crs));
      acc(0, 1, 1, 8'h05, 8'h00);
      chk("disp_region", 16'(REG_DISPLAY), 16'(rgs));
      chk("disp_rdata", 16'h0000, 16'(rdata));
      bw = 1'b0;
      acc(1, 0, 0, 8'hc8, 8'h82);
      chk("bitop_wr", 0, 16'(cws));
      bw = 1'b1;
   endtask
   task automatic t_paging();
      acc(1, 0, 0, 8'hf3, 8'h01);
      chk("page_sel", 16'h0001, 16'(pg));
      acc(1, 0, 0, 8'hbf, 8'h77);
      acc(1, 0, 0, 8'h20, 8'haa);
      dp = 1'b1;
      acc(1, 0, 0, 8'h20, 8'h55);
      dp = 1'b0;
      acc(0, 1, 0, 8'h20, 8'h00);
      chk("page0", 16'h00aa, 16'(rdata));
      dp = 1'b1;
      acc(0, 1, 0, 8'h20, 8'h00);
      chk("page1", 16'h0055, 16'(rdata));
      dp = 1'b0;
      acc(0, 1, 0, 8'hbf, 8'h00);
      chk("last_loc", 16'h0077, 16'(rdata));
   endtask
   task automatic t_stack();
      @(negedge clk);
      sp_wr = 1'b1;
      spd = 8'hbf;
      @(negedge clk);
      sp_wr = 1'b0;
      chk("sp_load", 16'h00bf, 16'(sp));
      stk(STK_CALL, 16'h1234, 8'h00);
      chk("sp_call", 16'h00bd, 16'(sp));
      acc(0, 1, 0, 8'hbf, 8'h00);
      chk("push_hi", 16'h0012, 16'(rdata));
      acc(0, 1, 0, 8'hbe, 8'h00);
      chk("push_lo", 16'h0034, 16'(rdata));
      stk(STK_RET, 16'h0000, 8'h00);
      chk("ret_pc", 16'h1234, ppc);
      chk("ret_nostat", 0, 16'(phs));
      chk("ret_stat", 16'h0000, 16'(pst));
      chk("sp_ret", 16'h00bf, 16'(sp));
      stk(STK_IRQ, 16'habcd, 8'h5a);
      chk("sp_irq", 16'h00bc, 16'(sp));
      stk(STK_INTERRUPT_RETURN, 16'h0000, 8'h00);
      chk("interrupt_return_pc", 16'habcd, ppc);
      chk("interrupt_return_stat", 16'h005a, 16'(pst));
      chk("interrupt_return_has", 1, 16'(phs));
      chk("sp_interrupt_return", 16'h00bf, 16'(sp));
   endtask
   // --------------------
   // clock, reset, flow
   // --------------------
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial begin
      #20000;
      n_fail++;
      close_out();
   end
   initial begin
      {bw, dp, sp_wr, rf} = 4'h8;
      {req, rpc, st, spd, vidx} = '0;
      op = STK_NONE;
      n_fail = 0;
      n_compared = 0;
      rst_n = 1'b0;
      repeat (16) @(negedge clk);
      chk("vec_reset", 16'hfffe, va);
      rst_n = 1'b1;
      @(negedge clk);
      t_vectors();
      t_regions();
      t_paging();
      t_stack();
      close_out();
   end
endmodule
